// >>> core/hmad_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Mode 10b legacy only; 11b both windows
// - Base select: A0000H when clear, B8000H set
// - Legacy window reuses relocatable group offsets
// - Lower legacy 32K range takes image writes
// - Upper legacy position: no image transfers
// - Sequencer bit 7 refuses port I/O while a window is on
// - Relocatable 64M window at programmable base
// - Lower half little, upper half big endian
// - Mode 01b decodes relocatable window only
// - Reset mode 01b PCI, 00b otherwise
// - Frame buffer 16M, image port at 1000000
// - Bus config, overlay, memory, display groups
// - Status, function control, DMA, peripheral bus
// - Drawing engine groups at fixed bases
// - Gaps between groups are reserved
// - Big endian adds 2 to top digit
// - Retrace start extension bits, lock blocks writes
// - Retrace end lock, refresh override, unprotect
// - Bit 10 of four values; blank lockable
// - Line offset old and new extensions
// - Palette and DAC access gates
module hmad_decoder
  import hmad_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         pci_config,
  input  wire logic [5:0]   pci_base_hi,
  input  var  hmad_req_t    req,
  output var  hmad_rsp_t    rsp,
  output var  hmad_dn_t     dn,
  output var  hmad_timing_t timing
);

  logic [7:0]   cr_reg [NUM_CR];
  logic [7:0]   cr_next [NUM_CR];
  logic [7:0]   crt_idx_reg;
  logic [7:0]   crt_idx_next;
  logic [7:0]   seq_idx_reg;
  logic [7:0]   seq_idx_next;
  logic [7:0]   seq_io_reg;
  logic [7:0]   seq_io_next;
  logic [31:0]  advfc_reg;
  logic [31:0]  advfc_next;
  logic         strap_done_reg;
  logic         pci_cfg_reg;
  logic         pci_cfg_next;
  hmad_rsp_t    rsp_reg;
  hmad_rsp_t    rsp_next;
  hmad_dn_t     dn_reg;
  hmad_dn_t     dn_next;
  hmad_timing_t timing_reg;
  hmad_timing_t timing_next;

  logic [1:0]   mode;
  logic         old_en;
  logic         new_en;
  logic         base_hi;
  logic [5:0]   rel_base;
  logic         leg_hit;
  logic         rel_hit;
  logic         io_hit;
  logic         io_off;
  logic [24:0]  ofs;
  hmad_region_t region;
  logic [7:0]   port;
  logic [4:0]   slot;
  logic [31:0]  status;

  function automatic logic [4:0] cr_slot(input logic [7:0] idx);
    logic [4:0] s;
    s = 5'(NUM_CR);
    for (int i = 0; i < NUM_CR; i++) begin
      if (CR_IDX[i] == idx) s = 5'(i);
    end
    return s;
  endfunction : cr_slot

  function automatic logic [7:0] wr_mask(input logic [4:0] s,
                                          input logic       lock,
                                          input logic       vre_prot,
                                          input logic       unprot);
    logic [7:0] m;
    m = 8'hff;
    if (s == 5'(S_VRS) && lock) m = 8'h00;
    if (s == 5'(S_VBS) && lock) m = 8'h00;
    if (s == 5'(S_VRE) && lock) m = ~VRE_LOCK_BITS;
    if (s == 5'(S_MAXSCAN) && lock) m = ~MSL_LOCK_BITS;
    if (s == 5'(S_OVF)) begin
      if (lock) m = m & ~OVF_LOCK_BITS;
      if (vre_prot) begin
        // Old protect covers all but bit 4; the unprotect bit frees 1 and 6
        m = m & ~(unprot ? (OVF_VRE_PROT & ~OVF_UNPROT)
                         : OVF_VRE_PROT);
      end
    end
    return m;
  endfunction : wr_mask

  hmad_region_map u_map (
    .offset (ofs),
    .region (region)
  );

  // Window decode
  always_comb begin
    mode     = cr_reg[S_MMIO][MODE_LSB +: 2];
    old_en   = (mode == MODE_OLD) || (mode == MODE_BOTH);
    new_en   = (mode == MODE_NEW) || (mode == MODE_BOTH);
    base_hi  = cr_reg[S_MMIO][BASE_SEL_BIT];
    rel_base = pci_cfg_reg ? pci_base_hi
                           : cr_reg[S_LWP_HI][LWP_BASE_LSB +: 6];
    leg_hit  = old_en && !req.is_io &&
               (base_hi ? (req.addr[31:15] == LEGACY_HI_PAGE)
                        : (req.addr[31:16] == LEGACY_LO_PAGE));
    rel_hit  = new_en && !req.is_io &&
               (req.addr[31:WIN_LSB] == rel_base);
    io_hit   = req.is_io && (req.addr[15:8] == IO_PORT_HI) &&
               (req.addr[7:4] >= 4'hb) && (req.addr[7:4] <= 4'hd);
    // Port I/O refused only while some memory window is on
    io_off   = (mode != MODE_OFF) && seq_io_reg[SEQ_IO_OFF_BIT];
    // Legacy wins if both windows cover the same address
    if (leg_hit) begin
      // Upper position only reaches offsets 8000-FFFF, never the image port
      ofs = GROUP_OFS | {9'h000, req.addr[15:0]};
    end else if (rel_hit) begin
      ofs = req.addr[24:0];
    end else begin
      ofs = VGA_PORT_OFS | {17'h00000, req.addr[7:0]};
    end
    port = ofs[7:0];
    slot = cr_slot(crt_idx_reg);
    status = 32'h00000000;
    status[STAT_MODE_LSB +: 2] = mode;
    status[STAT_BASE_BIT]      = base_hi;
    status[STAT_PCI_BIT]       = pci_cfg_reg;
    status[STAT_IOOFF_BIT]     = seq_io_reg[SEQ_IO_OFF_BIT];
  end

  // Register accesses and downstream forwarding
  always_comb begin
    logic claim;
    logic internal;
    logic blocked;
    logic [7:0] m;
    claim        = 1'b0;
    internal     = 1'b0;
    blocked      = 1'b0;
    m            = 8'h00;
    cr_next      = cr_reg;
    crt_idx_next = crt_idx_reg;
    seq_idx_next = seq_idx_reg;
    seq_io_next  = seq_io_reg;
    advfc_next   = advfc_reg;
    pci_cfg_next = pci_cfg_reg;
    rsp_next     = '0;
    dn_next      = '0;
    dn_next.region = RG_RESERVED;

    if (req.valid) begin
      claim = leg_hit || rel_hit || io_hit;
      rsp_next.ack     = 1'b1;
      rsp_next.claimed = claim;
      if (io_hit && io_off) begin
        blocked = 1'b1;
      end
      if (claim && !blocked) begin
        unique case (region)
          RG_VGA3B, RG_VGA3C, RG_VGA3D: begin
            if (port == PORT_CRT_IDX) begin
              internal = 1'b1;
              rsp_next.rdata[7:0] = crt_idx_reg;
              if (req.write) crt_idx_next = req.wdata[7:0];
            end else if (port == PORT_CRT_DAT && slot != 5'(NUM_CR)) begin
              internal = 1'b1;
              rsp_next.rdata[7:0] = cr_reg[slot];
              m = wr_mask(slot, cr_reg[S_LOCK][LOCK_VERT_BIT],
                          cr_reg[S_VRE][VRE_PROT_BIT],
                          cr_reg[S_COMPAT][COMPAT_OVF_BIT]);
              if (req.write) begin
                cr_next[slot] = (cr_reg[slot] & ~m) | (req.wdata[7:0] & m);
              end
            end else if (port == PORT_SEQ_IDX) begin
              internal = 1'b1;
              rsp_next.rdata[7:0] = seq_idx_reg;
              if (req.write) seq_idx_next = req.wdata[7:0];
            end else if (port == PORT_SEQ_DAT && seq_idx_reg == SEQ_IO_IDX) begin
              internal = 1'b1;
              rsp_next.rdata[7:0] = seq_io_reg;
              if (req.write) seq_io_next = req.wdata[7:0];
            end else if ((port == PORT_ATTR_IDX || port == PORT_ATTR_DAT) &&
                         cr_reg[S_COMPAT][COMPAT_ATTR_BIT]) begin
              blocked = 1'b1;
            end else if (req.write && port >= PORT_DAC_LO &&
                         port <= PORT_DAC_HI &&
                         cr_reg[S_COMPAT][COMPAT_DAC_BIT]) begin
              blocked = 1'b1;
            end
          end
          RG_SUBSTAT: begin
            internal = 1'b1;
            rsp_next.rdata = status;
          end
          RG_ADVFC: begin
            internal = 1'b1;
            rsp_next.rdata = advfc_reg;
            if (req.write) advfc_next = req.wdata;
          end
          RG_RESERVED: begin
            internal = 1'b1;
          end
          RG_LFB, RG_IMAGE, RG_BUSCFG, RG_OVERLAY, RG_MEMPORT, RG_DMA,
          RG_PATTERN, RG_BLT, RG_LINE2D, RG_POLY2D, RG_LINE3D, RG_TRI3D,
          RG_LPB: begin
            internal = 1'b0;
          end
        endcase
      end
      rsp_next.refused = blocked;
      if (claim && !blocked && !internal) begin
        dn_next.valid      = 1'b1;
        dn_next.write      = req.write;
        // Any write to an address in the image port is accepted as pixel data
        dn_next.image      = req.write && (region == RG_IMAGE);
        dn_next.big_endian = rel_hit && !leg_hit &&
                             req.addr[ENDIAN_BIT];
        dn_next.region     = region;
        dn_next.offset     = ofs;
        dn_next.wdata      = req.wdata;
      end
    end

    // Strap is sampled once, on the first edge after reset release
    if (!strap_done_reg) begin
      pci_cfg_next = pci_config;
      cr_next[S_MMIO][MODE_LSB +: 2] = pci_config ? MODE_NEW
                                                  : MODE_OFF;
    end
  end

  // Derived display timing values
  always_comb begin
    timing_next.vretrace_start = {cr_reg[S_VOVF][4], cr_reg[S_OVF][7],
                                  cr_reg[S_OVF][2], cr_reg[S_VRS]};
    timing_next.display_end    = {cr_reg[S_VOVF][1], cr_reg[S_OVF][6],
                                  cr_reg[S_OVF][1], cr_reg[S_VDE]};
    timing_next.vblank_start   = {cr_reg[S_VOVF][2], cr_reg[S_MAXSCAN][5],
                                  cr_reg[S_OVF][3], cr_reg[S_VBS]};
    timing_next.line_compare   = {cr_reg[S_VOVF][6], cr_reg[S_MAXSCAN][6],
                                  cr_reg[S_OVF][4], cr_reg[S_LCMP]};
    // New extension bits take precedence once software sets them
    if (cr_reg[S_EXTSYS][EXTSYS_LO_LSB +: 2] != 2'b00) begin
      timing_next.line_offset = {cr_reg[S_EXTSYS][EXTSYS_LO_LSB +: 2],
                                 cr_reg[S_LOFS]};
    end else begin
      timing_next.line_offset = {1'b0, cr_reg[S_EXTMODE][EXTMODE_LO8_BIT],
                                 cr_reg[S_LOFS]};
    end
    if (cr_reg[S_MISC][MISC_OVR_BIT]) begin
      timing_next.refresh_sel = cr_reg[S_MISC][1:0];
    end else begin
      timing_next.refresh_sel = {1'b0, cr_reg[S_VRE][VRE_REFR_BIT]};
    end
    timing_next.attr_access_en = !cr_reg[S_COMPAT][COMPAT_ATTR_BIT];
    timing_next.dac_write_en   = !cr_reg[S_COMPAT][COMPAT_DAC_BIT];
    timing_next.mmio_mode      = mode;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CR; i++) begin
        cr_reg[i] <= CR_RESET;
      end
      crt_idx_reg    <= 8'h00;
      seq_idx_reg    <= 8'h00;
      seq_io_reg     <= 8'h00;
      advfc_reg      <= 32'h00000000;
      strap_done_reg <= 1'b0;
      pci_cfg_reg    <= 1'b0;
      rsp_reg        <= '0;
      dn_reg         <= '0;
      timing_reg     <= '0;
    end else begin
      cr_reg         <= cr_next;
      crt_idx_reg    <= crt_idx_next;
      seq_idx_reg    <= seq_idx_next;
      seq_io_reg     <= seq_io_next;
      advfc_reg      <= advfc_next;
      strap_done_reg <= 1'b1;
      pci_cfg_reg    <= pci_cfg_next;
      rsp_reg        <= rsp_next;
      dn_reg         <= dn_next;
      timing_reg     <= timing_next;
    end
  end

  assign rsp    = rsp_reg;
  assign dn     = dn_reg;
  assign timing = timing_reg;

endmodule : hmad_decoder
`default_nettype wire

// >>> core/hmad_pkg.sv
package hmad_pkg;

  // Window-mode field encodings
  localparam logic [1:0] MODE_OFF  = 2'b00;
  localparam logic [1:0] MODE_NEW  = 2'b01;
  localparam logic [1:0] MODE_OLD  = 2'b10;
  localparam logic [1:0] MODE_BOTH = 2'b11;

  // Field positions
  localparam int MODE_LSB        = 3;
  localparam int BASE_SEL_BIT    = 5;
  localparam int SEQ_IO_OFF_BIT  = 7;
  localparam int LOCK_VERT_BIT   = 4;
  localparam int COMPAT_OVF_BIT  = 1;
  localparam int COMPAT_DAC_BIT  = 4;
  localparam int COMPAT_ATTR_BIT = 6;
  localparam int VRE_PROT_BIT    = 7;
  localparam int VRE_REFR_BIT    = 6;
  localparam int MISC_OVR_BIT    = 2;
  localparam int EXTMODE_LO8_BIT = 2;
  localparam int EXTSYS_LO_LSB   = 4;
  localparam int LWP_BASE_LSB    = 2;

  // Status word layout
  localparam int STAT_MODE_LSB  = 0;
  localparam int STAT_BASE_BIT  = 2;
  localparam int STAT_PCI_BIT   = 3;
  localparam int STAT_IOOFF_BIT = 4;

  // Write masks for lockable bits
  localparam logic [7:0] OVF_LOCK_BITS = 8'had;
  localparam logic [7:0] OVF_VRE_PROT  = 8'hef;
  localparam logic [7:0] OVF_UNPROT    = 8'h42;
  localparam logic [7:0] VRE_LOCK_BITS = 8'h0f;
  localparam logic [7:0] MSL_LOCK_BITS = 8'h20;

  // Window geometry
  localparam logic [15:0] LEGACY_LO_PAGE = 16'h000a;
  localparam logic [16:0] LEGACY_HI_PAGE = 17'h00017;
  localparam logic [24:0] GROUP_OFS      = 25'h1000000;
  localparam logic [24:0] VGA_PORT_OFS   = 25'h1008300;
  localparam int          WIN_LSB        = 26;
  localparam int          ENDIAN_BIT     = 25;
  localparam logic [7:0]  IO_PORT_HI     = 8'h03;

  // Legacy display ports, low byte
  localparam logic [7:0] PORT_ATTR_IDX = 8'hc0;
  localparam logic [7:0] PORT_ATTR_DAT = 8'hc1;
  localparam logic [7:0] PORT_SEQ_IDX  = 8'hc4;
  localparam logic [7:0] PORT_SEQ_DAT  = 8'hc5;
  localparam logic [7:0] PORT_DAC_LO   = 8'hc6;
  localparam logic [7:0] PORT_DAC_HI   = 8'hc9;
  localparam logic [7:0] PORT_CRT_IDX  = 8'hd4;
  localparam logic [7:0] PORT_CRT_DAT  = 8'hd5;
  localparam logic [7:0] SEQ_IO_IDX    = 8'h09;

  // Register groups of the relocatable map
  typedef enum logic [4:0] {
    RG_LFB, RG_IMAGE, RG_BUSCFG, RG_OVERLAY, RG_MEMPORT, RG_VGA3B,
    RG_VGA3C, RG_VGA3D, RG_SUBSTAT, RG_ADVFC, RG_DMA, RG_PATTERN,
    RG_BLT, RG_LINE2D, RG_POLY2D, RG_LINE3D, RG_TRI3D, RG_LPB,
    RG_RESERVED
  } hmad_region_t;

  localparam int NUM_REGIONS = 18;
  localparam logic [24:0] REGION_LO [NUM_REGIONS] = '{
    25'h0000000, 25'h1000000, 25'h1008000, 25'h1008180, 25'h1008200,
    25'h10083b0, 25'h10083c0, 25'h10083d0, 25'h1008504, 25'h100850c,
    25'h1008580, 25'h100a000, 25'h100a400, 25'h100a800, 25'h100ac00,
    25'h100b000, 25'h100b400, 25'h100ff00};
  localparam logic [24:0] REGION_HI [NUM_REGIONS] = '{
    25'h0ffffff, 25'h1007fff, 25'h1008043, 25'h10081ff, 25'h1008224,
    25'h10083bf, 25'h10083cf, 25'h10083df, 25'h1008507, 25'h100850f,
    25'h10085ff, 25'h100a1ff, 25'h100a5ff, 25'h100a9ff, 25'h100adff,
    25'h100b1ff, 25'h100b5ff, 25'h100ff5f};

  // Display-controller registers held here: slot and index
  localparam int NUM_CR    = 17;
  localparam int S_MMIO    = 0;
  localparam int S_LWP_HI  = 1;
  localparam int S_LWP_LO  = 2;
  localparam int S_LOCK    = 3;
  localparam int S_COMPAT  = 4;
  localparam int S_VOVF    = 5;
  localparam int S_OVF     = 6;
  localparam int S_MISC    = 7;
  localparam int S_VRS     = 8;
  localparam int S_VRE     = 9;
  localparam int S_VDE     = 10;
  localparam int S_LOFS    = 11;
  localparam int S_VBS     = 12;
  localparam int S_LCMP    = 13;
  localparam int S_EXTMODE = 14;
  localparam int S_EXTSYS  = 15;
  localparam int S_MAXSCAN = 16;
  localparam logic [7:0] CR_IDX [NUM_CR] = '{
    8'h53, 8'h59, 8'h5a, 8'h35, 8'h33, 8'h5e, 8'h07, 8'h3a, 8'h10,
    8'h11, 8'h12, 8'h13, 8'h15, 8'h18, 8'h43, 8'h51, 8'h09};
  localparam logic [7:0] CR_RESET = 8'h00;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hmad_req_t;

  typedef struct packed {
    logic        ack;
    logic        claimed;
    logic        refused;
    logic [31:0] rdata;
  } hmad_rsp_t;

  typedef struct packed {
    logic         valid;
    logic         write;
    logic         image;
    logic         big_endian;
    hmad_region_t region;
    logic [24:0]  offset;
    logic [31:0]  wdata;
  } hmad_dn_t;

  typedef struct packed {
    logic [10:0] vretrace_start;
    logic [10:0] display_end;
    logic [10:0] vblank_start;
    logic [10:0] line_compare;
    logic [9:0]  line_offset;
    logic [1:0]  refresh_sel;
    logic        attr_access_en;
    logic        dac_write_en;
    logic [1:0]  mmio_mode;
  } hmad_timing_t;

endpackage : hmad_pkg

// >>> core/hmad_region_map.sv
`timescale 1ns/1ps
`default_nettype none
module hmad_region_map
  import hmad_pkg::*;
(
  input  wire logic [24:0]  offset,
  output var hmad_region_t  region
);

  // Gaps between groups fall through to the reserved answer
  always_comb begin
    region = RG_RESERVED;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (offset >= REGION_LO[i] && offset <= REGION_HI[i]) begin
        region = hmad_region_t'(i);
      end
    end
  end

endmodule : hmad_region_map
`default_nettype wire

// >>> verification/hmad_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) \
  begin n_mismatch++; $display("FAIL %s exp %0h got %0h", nm, ex, got); \
  end end
module hmad_decoder_bench import hmad_pkg::*;;
  logic         sys_clk = 1'h0;
  logic         rst_n;
  logic         pci_config;
  logic [5:0]   pci_base_hi;
  hmad_req_t    req;
  hmad_rsp_t    rsp;
  hmad_rsp_t    rr;
  hmad_dn_t     dn;
  hmad_dn_t     dd;
  hmad_timing_t timing;
  int           n_mismatch;
  int           samples_checked;
  int           cycles;
  logic [31:0]  a;

  localparam logic [24:0] T_OFS [17] = '{
    25'h0000010, 25'h0ffffff, 25'h1007ffc, 25'h1008000, 25'h1008043,
    25'h1008180, 25'h1008224, 25'h10083b4, 25'h10083da, 25'h1008580,
    25'h100a000, 25'h100a5ff, 25'h100a800, 25'h100ac00, 25'h100b000,
    25'h100b400, 25'h100ff5c};
  localparam hmad_region_t T_RG [17] = '{
    RG_LFB, RG_LFB, RG_IMAGE, RG_BUSCFG, RG_BUSCFG, RG_OVERLAY,
    RG_MEMPORT, RG_VGA3B, RG_VGA3D, RG_DMA, RG_PATTERN, RG_BLT,
    RG_LINE2D, RG_POLY2D, RG_LINE3D, RG_TRI3D, RG_LPB};

  always #12.5 sys_clk = ~sys_clk;

  hmad_decoder uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .pci_config(pci_config), .pci_base_hi(pci_base_hi), .req(req),
    .rsp(rsp), .dn(dn), .timing(timing));
  hmad_host_model host (.sys_clk(sys_clk), .req(req), .rsp(rsp), .dn(dn));

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic acc(input logic io, input logic wr, input logic [31:0] ad,
                     input logic [31:0] d);
    host.xfer(io, wr, ad, d, rr, dd);
  endtask : acc

  task automatic crw(input logic [7:0] ix, input logic [7:0] v);
    acc(1'h1, 1'h1, 32'h000003d4, {24'h0, ix});
    acc(1'h1, 1'h1, 32'h000003d5, {24'h0, v});
  endtask : crw

  // Timing outputs trail the registers by one edge
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  // Extra edges after release let the strap load the window mode
  task automatic do_reset(input logic pci);
    @(posedge sys_clk);
    #1;
    rst_n = 1'h0;
    pci_config = pci;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'h1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : do_reset

  initial begin
    rst_n = 1'h0;
    pci_config = 1'h0;
    pci_base_hi = 6'h05;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    do_reset(1'h0);
    `CK("mode", MODE_OFF, timing.mmio_mode)
    acc(1'h0, 1'h0, 32'h000a8000, 32'h0);
    `CK("claim", 1'h0, rr.claimed)
    crw(8'h53, 8'h10);
    for (int i = 0; i < 2; i++) begin
      a = i ? 32'h000a7ffc : 32'h000a0010;
      acc(1'h0, 1'h1, a, 32'h12345678);
      `CK("image", 1'h1, dd.image)
      `CK("iack", 1'h1, rr.ack)
      `CK("iwr", 1'h1, dd.write)
      `CK("idat", 32'h12345678, dd.wdata)
      `CK("iofs", {9'h100, a[15:0]}, dd.offset)
    end
    acc(1'h0, 1'h0, 32'h000a8000, 32'h0);
    `CK("legreg", RG_BUSCFG, dd.region)
    crw(8'h59, 8'h20);
    acc(1'h0, 1'h1, 32'h21008000, 32'h0);
    `CK("legonly", 1'h0, rr.claimed)
    crw(8'h53, 8'h18);
    acc(1'h0, 1'h1, 32'h21008000, 32'h0);
    `CK("both", RG_BUSCFG, dd.region)
    acc(1'h0, 1'h1, 32'h000a8000, 32'h0);
    `CK("bothleg", 1'h1, dd.valid)
    crw(8'h53, 8'h08);
    acc(1'h0, 1'h1, 32'h000a8000, 32'h0);
    `CK("newonly", 1'h0, rr.claimed)
    crw(8'h53, 8'h38);
    acc(1'h0, 1'h1, 32'h000b8000, 32'h0);
    `CK("upreg", RG_BUSCFG, dd.region)
    `CK("upimg", 1'h0, dd.image)
    acc(1'h0, 1'h1, 32'h000a0010, 32'h0);
    `CK("lowoff", 1'h0, dd.valid)
    acc(1'h1, 1'h1, 32'h000003c4, 32'h09);
    acc(1'h1, 1'h1, 32'h000003c5, 32'h80);
    acc(1'h1, 1'h0, 32'h000003d5, 32'h0);
    `CK("iooff", 1'h1, rr.refused)
    acc(1'h0, 1'h0, 32'h21008504, 32'h0);
    `CK("stat", 5'h17, rr.rdata[4:0])
    acc(1'h0, 1'h1, 32'h210083c5, 32'h00);
    acc(1'h1, 1'h0, 32'h000003d5, 32'h0);
    `CK("ioon", 1'h0, rr.refused)
    crw(8'h10, 8'h5a);
    crw(8'h07, 8'h84);
    crw(8'h5e, 8'h56);
    crw(8'h12, 8'h11);
    crw(8'h15, 8'h22);
    crw(8'h18, 8'h33);
    settle();
    `CK("vrs", 11'h75a, timing.vretrace_start)
    `CK("vde", 11'h411, timing.display_end)
    `CK("vbs", 11'h422, timing.vblank_start)
    `CK("lcmp", 11'h433, timing.line_compare)
    crw(8'h35, 8'h10);
    crw(8'h10, 8'h00);
    crw(8'h15, 8'h00);
    crw(8'h12, 8'h55);
    crw(8'h18, 8'h66);
    crw(8'h11, 8'h4f);
    settle();
    `CK("vrslk", 11'h75a, timing.vretrace_start)
    `CK("vbslk", 11'h422, timing.vblank_start)
    `CK("vdelk", 11'h455, timing.display_end)
    `CK("lcmplk", 11'h466, timing.line_compare)
    `CK("refr", 2'h1, timing.refresh_sel)
    acc(1'h1, 1'h1, 32'h000003d4, 32'h11);
    acc(1'h1, 1'h0, 32'h000003d5, 32'h0);
    `CK("vrelk", 8'h40, rr.rdata[7:0])
    crw(8'h3a, 8'h06);
    settle();
    `CK("refovr", 2'h2, timing.refresh_sel)
    crw(8'h35, 8'h00);
    crw(8'h11, 8'h80);
    crw(8'h07, 8'h42);
    settle();
    `CK("ovfprot", 11'h455, timing.display_end)
    crw(8'h33, 8'h02);
    crw(8'h07, 8'h42);
    settle();
    `CK("ovffree", 11'h755, timing.display_end)
    `CK("ovfkeep", 11'h75a, timing.vretrace_start)
    crw(8'h13, 8'h11);
    crw(8'h43, 8'h04);
    settle();
    `CK("lofs8", 10'h111, timing.line_offset)
    crw(8'h51, 8'h20);
    settle();
    `CK("lofs98", 10'h211, timing.line_offset)
    crw(8'h33, 8'h40);
    acc(1'h1, 1'h1, 32'h000003c0, 32'h0);
    `CK("attr", 1'h1, rr.refused)
    `CK("attren", 1'h0, timing.attr_access_en)
    acc(1'h1, 1'h1, 32'h000003c8, 32'h0);
    `CK("dacok", 1'h0, rr.refused)
    `CK("dacon", 1'h1, timing.dac_write_en)
    crw(8'h33, 8'h10);
    acc(1'h1, 1'h1, 32'h000003c8, 32'h0);
    `CK("dacwr", 1'h1, rr.refused)
    `CK("dacen", 1'h0, timing.dac_write_en)
    acc(1'h1, 1'h0, 32'h000003c8, 32'h0);
    `CK("dacrd", 1'h0, rr.refused)
    do_reset(1'h1);
    `CK("pmode", MODE_NEW, timing.mmio_mode)
    acc(1'h0, 1'h0, 32'h15008504, 32'h0);
    `CK("pstat", 5'h09, rr.rdata[4:0])
    acc(1'h0, 1'h1, 32'h1500850c, 32'ha5a55a5a);
    acc(1'h0, 1'h0, 32'h1500850c, 32'h0);
    `CK("afc", 32'ha5a55a5a, rr.rdata)
    `CK("afcint", 1'h0, dd.valid)
    for (int i = 0; i < 17; i++) begin
      for (int h = 0; h < 2; h++) begin
        a = {6'h05, h[0], T_OFS[i]};
        acc(1'h0, 1'h1, a, 32'h0);
        `CK("rg", T_RG[i], dd.region)
        `CK("ofs", T_OFS[i], dd.offset)
        `CK("be", h[0], dd.big_endian)
      end
    end
    acc(1'h0, 1'h0, 32'h15008044, 32'h0);
    `CK("gapc", 1'h1, rr.claimed)
    `CK("gapf", 1'h0, dd.valid)
    acc(1'h0, 1'h0, 32'h19008000, 32'h0);
    `CK("out", 1'h0, rr.claimed)
    report_and_stop();
  end
endmodule : hmad_decoder_bench

bind hmad_decoder hmad_decoder_checker chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .pci_config(pci_config), .pci_base_hi(pci_base_hi),
  .req(req), .rsp(rsp), .dn(dn), .timing(timing));
`default_nettype wire

// >>> verification/hmad_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none
module hmad_decoder_checker
  import hmad_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire logic         pci_config,
  input wire logic [5:0]   pci_base_hi,
  input var  hmad_req_t    req,
  input var  hmad_rsp_t    rsp,
  input var  hmad_dn_t     dn,
  input var  hmad_timing_t timing
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic win_hit;
  // Base zero would overlap the legacy window, so it is left out here
  assign win_hit = req.valid && !req.is_io && pci_config &&
                   pci_base_hi != 6'h00 && req.addr[31:26] == pci_base_hi &&
                   timing.mmio_mode[0];

  chk_ack_latency: assert property (req.valid |=> rsp.ack)
    else $error("request not acknowledged one cycle later");
  chk_reset_mode: assert property ($rose(rst_n) |-> ##3
    timing.mmio_mode == (pci_config ? MODE_NEW : MODE_OFF))
    else $error("window mode wrong after reset");
  chk_window_claim: assert property (win_hit |=> rsp.claimed)
    else $error("relocatable window access not claimed");
  chk_endian_offset: assert property (win_hit |=> !dn.valid ||
    (dn.offset == $past(req.addr[24:0]) &&
     dn.big_endian == $past(req.addr[25])))
    else $error("forwarded offset or endian half wrong");
  chk_image_region: assert property (dn.valid && dn.image |->
    dn.region == RG_IMAGE && dn.write && dn.offset[24:15] == 10'h200)
    else $error("image transfer outside image region");
  chk_upper_no_image: assert property (req.valid && !req.is_io &&
    req.addr[31:15] == 17'h00017 |=> !dn.image)
    else $error("image transfer from upper legacy window");
  chk_refused_quiet: assert property (rsp.refused |->
    !dn.valid && rsp.rdata == 32'h0)
    else $error("refused access had an effect");
  chk_retrace_cause: assert property (
    $changed(timing.vretrace_start) |-> $past(req.valid, 2) &&
    $past(req.write, 2))
    else $error("retrace start changed without a write");
  chk_attr_gate: assert property (req.valid && req.is_io &&
    req.addr[15:0] == 16'h03c0 && !timing.attr_access_en |=> rsp.refused)
    else $error("gated attribute access not refused");
endmodule : hmad_decoder_checker
`default_nettype wire

// >>> verification/hmad_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hmad_host_model
  import hmad_pkg::*;
(
  input  wire logic      sys_clk,
  output var  hmad_req_t req,
  input  var  hmad_rsp_t rsp,
  input  var  hmad_dn_t  dn
);
  initial req = '0;

  // Between requests the bus shows the inverse of the last one, never a copy
  task automatic xfer(input logic io, input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output hmad_rsp_t r,
                      output hmad_dn_t n);
    logic [31:0] aa;
    aa = a;
    if (!io && wr && a[31:15] == 17'h00014) begin
      aa[1:0] = 2'h0;
    end
    @(posedge sys_clk);
    #1;
    req = '{1'h1, io, wr, aa, d};
    @(posedge sys_clk);
    #1;
    r = rsp;
    n = dn;
    req = '{1'h0, ~io, ~wr, ~aa, ~d};
  endtask : xfer
endmodule : hmad_host_model
`default_nettype wire
